// ---- include/ldc_cfg.svh ----
// Purpose: shared constants of the command decode and burst datapath
// Assumes: included by bare name from package and modules
// Notes:   burst length code travels with each burst
`ifndef LDC_CFG_SVH
`define LDC_CFG_SVH
`define LDC_BL4      2'h0
`define LDC_BL8      2'h1
`define LDC_BL16     2'h2
`define LDC_BA_LSB   7
`define LDC_BA_MSB   9
`define LDC_AB_BIT   4
`define LDC_RL_MIN   4'h2
`define LDC_RL_RST   4'h3
`define LDC_GAP_MAX  5'h1f
`endif

// ---- include/ldc_pkg.sv ----
// Purpose: types and helpers shared by the burst datapath
// Assumes: ldc_cfg.svh on the include path
// Notes:   column stepping wraps inside the burst boundary
`include "ldc_cfg.svh"
package ldc_pkg;
  typedef enum logic [1:0] {LDC_NONE, LDC_RD, LDC_BST} ldc_cmd_e;

  // Clocks per burst: beats over two
  function automatic logic [3:0] ldc_half(input logic [1:0] bl);
    unique case (bl)
      `LDC_BL4: ldc_half = 4'h2;
      `LDC_BL8: ldc_half = 4'h4;
      default:  ldc_half = 4'h8;
    endcase
  endfunction

  // Advance low column bits by one beat pair, wrapping in the burst
  function automatic logic [3:0] ldc_col_step(input logic [3:0] lo, input logic [1:0] bl);
    logic [3:0] h;
    logic [3:0] m;
    h = ldc_half(bl);
    m = {h[2:0], 1'b0} - 4'h1;
    if (bl != `LDC_BL4 && bl != `LDC_BL8) begin
      m = 4'hf;
    end
    ldc_col_step = (lo & ~m) | ((lo + 4'h2) & m);
  endfunction
endpackage

// ---- design/ldc_mem.sv ----
// Purpose: bank and column storage, one word per beat
// Assumes: writes come on the strobe clock, reads are asynchronous
// Notes:   pairs of beats sit at an even and the following odd address
`timescale 1ns/1ns
module ldc_mem #(
  parameter int DW = 16,
  parameter int AW = 9
) (
  input  wire logic          wclk_i,
  input  wire logic          we_i,
  input  wire logic [AW-1:0] waddr_i,
  input  wire logic [DW-1:0] wd0_i,
  input  wire logic [DW-1:0] wd1_i,
  input  wire logic [AW-1:0] raddr_i,
  output logic      [DW-1:0] rd0_o,
  output logic      [DW-1:0] rd1_o
);
  logic [DW-1:0] mem [2**AW];
  logic [AW-1:0] we_a;
  logic [AW-1:0] re_a;

  assign we_a = {waddr_i[AW-1:1], 1'b0};
  assign re_a = {raddr_i[AW-1:1], 1'b0};

  always_ff @(posedge wclk_i) begin
    if (we_i) begin
      mem[we_a]        <= wd0_i;
      mem[we_a | 'b1]  <= wd1_i;
    end
  end

  assign rd0_o = mem[re_a];
  assign rd1_o = mem[re_a | 'b1];
endmodule

// ---- design/ldc_wcap.sv ----
// Purpose: write burst capture on the strobe clock
// Assumes: strobe clock runs through the preamble, three edges at least
// Notes:   burst parameters are held steady by the command side
`timescale 1ns/1ns
`include "ldc_cfg.svh"
module ldc_wcap #(
  parameter int CW = 6
) (
  input  wire logic          wclk_i,
  input  wire logic          resetn_i,
  input  wire logic          msg_tgl_i,
  input  wire logic          restart_i,
  input  wire logic [2:0]    bank_i,
  input  wire logic [CW-1:0] col_i,
  input  wire logic [1:0]    bl_i,
  input  wire logic [4:0]    len_i,
  input  wire logic [4:0]    trunc_i,
  input  wire logic          wvalid_i,
  output logic               we_o,
  output logic [CW+2:0]      waddr_o
);
  logic rs1_reg, rs2_reg, t1_reg, t2_reg, t3_reg;
  logic [4:0] cnt_reg, lim_reg, plen_reg;
  logic [2:0] bank_reg, pbank_reg;
  logic [CW-1:0] col_reg, pcol_reg;
  logic [1:0] bl_reg, pbl_reg;
  logic pv_reg, chg, active, ld_msg, ld_pend, cut;

  // ---------------------------------------------------------------
  // Crossings
  // ---------------------------------------------------------------
  always_ff @(posedge wclk_i) begin
    rs1_reg <= resetn_i;
    rs2_reg <= rs1_reg;
  end

  always_ff @(posedge wclk_i) begin
    t1_reg <= msg_tgl_i;
    t2_reg <= t1_reg;
    t3_reg <= t2_reg;
  end

  assign chg     = t2_reg ^ t3_reg;
  assign active  = cnt_reg < lim_reg;
  assign ld_msg  = chg && restart_i && !active;
  assign ld_pend = !chg && !active && pv_reg;
  assign cut     = chg && active;
  assign we_o    = wvalid_i && active;
  assign waddr_o = {bank_reg, col_reg};

  // ---------------------------------------------------------------
  // Beat counter
  // ---------------------------------------------------------------
  always_ff @(posedge wclk_i) begin
    if (!rs2_reg) begin
      cnt_reg  <= 5'h0;
      lim_reg  <= 5'h0;
      bank_reg <= 3'h0;
      col_reg  <= '0;
      bl_reg   <= `LDC_BL4;
    end else if (ld_msg) begin
      cnt_reg  <= 5'h0;
      lim_reg  <= len_i;
      bank_reg <= bank_i;
      col_reg  <= col_i;
      bl_reg   <= bl_i;
    end else if (ld_pend) begin
      cnt_reg  <= 5'h0;
      lim_reg  <= plen_reg;
      bank_reg <= pbank_reg;
      col_reg  <= pcol_reg;
      bl_reg   <= pbl_reg;
    end else begin
      if (we_o) begin
        cnt_reg <= cnt_reg + 5'h2;
        col_reg <= {col_reg[CW-1:4], ldc_pkg::ldc_col_step(col_reg[3:0], bl_reg)};
      end
      if (cut) begin
        lim_reg <= trunc_i;
      end
    end
  end

  // Interrupting write waits here until the cut burst drains
  always_ff @(posedge wclk_i) begin
    if (!rs2_reg) begin
      pv_reg <= 1'b0;
    end else if (cut && restart_i) begin
      pv_reg    <= 1'b1;
      pbank_reg <= bank_i;
      pcol_reg  <= col_i;
      pbl_reg   <= bl_i;
      plen_reg  <= len_i;
    end else if (ld_pend) begin
      pv_reg <= 1'b0;
    end
  end
endmodule

// ---- design/ldc_top.sv ----
// Purpose: command decode, read latency pipe and burst engines
// Assumes: host holds CA falling half on ca_f_i in the command cycle
// Notes:   read data pairs leave per clock, strobe high means one toggle pair
`timescale 1ns/1ns
`include "ldc_cfg.svh"
module ldc_top #(
  parameter int DW    = 16,
  parameter int CW    = 6,
  parameter int RLMAX = 8
) (
  input  wire logic          sys_clk_i,
  input  wire logic          resetn_i,
  input  wire logic          clk_en_i,
  input  wire logic          cs_n_i,
  input  wire logic [9:0]    ca_r_i,
  input  wire logic [9:0]    ca_f_i,
  input  wire logic [3:0]    rl_cfg_i,
  input  wire logic [1:0]    bl_cfg_i,
  input  wire logic          dqs_clk_i,
  input  wire logic          dq_wvalid_i,
  input  wire logic [DW-1:0] dq_wr_r_i,
  input  wire logic [DW-1:0] dq_wr_f_i,
  output logic      [DW-1:0] dq_r_o,
  output logic      [DW-1:0] dq_f_o,
  output logic               dq_oe_o,
  output logic               dqs_o,
  output logic               dqs_oe_o,
  output logic      [7:0]    bank_open_o,
  output logic               cmd_err_o
);
  localparam int AW = 3 + CW;
  localparam int LW = $clog2(RLMAX);

  if (RLMAX < 3 || RLMAX > 15 || CW < 5 || CW > 11 || DW < 1) begin : g_chk
    $error("ldc_top: unsupported parameter values");
  end

  // ---------------------------------------------------------------
  // Command decode
  // ---------------------------------------------------------------
  logic          ce;
  logic          is_act, is_col, is_rd, is_wr, is_bst, is_pre;
  logic [2:0]    act_bank;
  logic [10:0]   col_w;
  logic [CW-1:0] col_a;

  assign ce       = clk_en_i;
  assign is_act   = !cs_n_i && !ca_r_i[0] && ca_r_i[1];
  assign is_col   = !cs_n_i && ca_r_i[0] && !ca_r_i[1];
  assign is_rd    = is_col && ca_r_i[2];
  assign is_wr    = is_col && !ca_r_i[2];
  assign is_bst   = !cs_n_i && ca_r_i[0] && ca_r_i[1] && !ca_r_i[2] && !ca_r_i[3];
  assign is_pre   = !cs_n_i && ca_r_i[0] && ca_r_i[1] && !ca_r_i[2] && ca_r_i[3];
  assign act_bank = ca_r_i[`LDC_BA_MSB:`LDC_BA_LSB];
  assign col_w    = {ca_f_i[9:1], ca_r_i[6:5]};
  assign col_a    = col_w[CW-1:0];

  // ---------------------------------------------------------------
  // Mode settings
  // ---------------------------------------------------------------
  logic [3:0] rl_reg;
  logic [1:0] bl_reg;
  logic [3:0] half;
  logic [3:0] half_m1;

  always_ff @(posedge sys_clk_i) begin
    if (!resetn_i) begin
      rl_reg <= `LDC_RL_RST;
      bl_reg <= `LDC_BL4;
    end else if (ce) begin
      bl_reg <= bl_cfg_i;
      if (rl_cfg_i < `LDC_RL_MIN) begin
        rl_reg <= `LDC_RL_MIN;
      end else if (rl_cfg_i > 4'(RLMAX)) begin
        rl_reg <= 4'(RLMAX);
      end else begin
        rl_reg <= rl_cfg_i;
      end
    end
  end

  assign half    = ldc_pkg::ldc_half(bl_reg);
  assign half_m1 = half - 4'h1;

  // ---------------------------------------------------------------
  // Bank state
  // ---------------------------------------------------------------
  logic [7:0] bank_open_reg;

  always_ff @(posedge sys_clk_i) begin
    if (!resetn_i) begin
      bank_open_reg <= 8'h00;
    end else if (ce) begin
      if (is_act) begin
        bank_open_reg[act_bank] <= 1'b1;
      end else if (is_pre && ca_r_i[`LDC_AB_BIT]) begin
        bank_open_reg <= 8'h00;
      end else if (is_pre) begin
        bank_open_reg[act_bank] <= 1'b0;
      end
    end
  end

  assign bank_open_o = bank_open_reg;

  // ---------------------------------------------------------------
  // Column history and misuse flag
  // ---------------------------------------------------------------
  logic [4:0] gap_reg;
  logic       last_rd_reg;
  logic       seen_reg;
  logic       in_burst;
  logic       bad_int;
  logic       closed;
  logic       cmd_err_reg;

  always_ff @(posedge sys_clk_i) begin
    if (!resetn_i) begin
      gap_reg     <= `LDC_GAP_MAX;
      last_rd_reg <= 1'b0;
      seen_reg    <= 1'b0;
    end else if (ce) begin
      if (is_col) begin
        gap_reg     <= 5'h1;
        last_rd_reg <= is_rd;
        seen_reg    <= 1'b1;
      end else if (gap_reg != `LDC_GAP_MAX) begin
        gap_reg <= gap_reg + 5'h1;
      end
    end
  end

  assign in_burst = seen_reg && (gap_reg < {1'b0, half});
  // Illegal interrupts: any cut of BL4, mixed kinds, odd spacing
  assign bad_int  = is_col && in_burst &&
                    (bl_reg == `LDC_BL4 || is_rd != last_rd_reg || gap_reg[0]);
  assign closed   = is_col && !bank_open_reg[act_bank];

  always_ff @(posedge sys_clk_i) begin
    if (!resetn_i) begin
      cmd_err_reg <= 1'b0;
    end else if (ce) begin
      cmd_err_reg <= bad_int || closed;
    end
  end

  assign cmd_err_o = cmd_err_reg;

  // ---------------------------------------------------------------
  // Read latency pipe
  // ---------------------------------------------------------------
  ldc_pkg::ldc_cmd_e dl_cmd  [RLMAX];
  logic [AW-1:0]     dl_addr [RLMAX];
  ldc_pkg::ldc_cmd_e tap_cmd;
  ldc_pkg::ldc_cmd_e pre_cmd;
  logic [AW-1:0]     tap_addr;

  always_ff @(posedge sys_clk_i) begin
    if (!resetn_i) begin
      for (int i = 0; i < RLMAX; i++) begin
        dl_cmd[i] <= ldc_pkg::LDC_NONE;
      end
    end else if (ce) begin
      if (is_rd) begin
        dl_cmd[0] <= ldc_pkg::LDC_RD;
      end else if (is_bst && last_rd_reg) begin
        dl_cmd[0] <= ldc_pkg::LDC_BST;
      end else begin
        dl_cmd[0] <= ldc_pkg::LDC_NONE;
      end
      for (int i = 1; i < RLMAX; i++) begin
        dl_cmd[i] <= dl_cmd[i-1];
      end
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (ce) begin
      dl_addr[0] <= {act_bank, col_a};
      for (int i = 1; i < RLMAX; i++) begin
        dl_addr[i] <= dl_addr[i-1];
      end
    end
  end

  // Tap RL-1 feeds the data edge RL, tap RL-2 the preamble
  assign tap_cmd  = dl_cmd[LW'(rl_reg - 4'h1)];
  assign tap_addr = dl_addr[LW'(rl_reg - 4'h1)];
  assign pre_cmd  = dl_cmd[LW'(rl_reg - 4'h2)];

  // ---------------------------------------------------------------
  // Read burst engine
  // ---------------------------------------------------------------
  logic [3:0]    left_reg;
  logic [2:0]    rbank_reg;
  logic [CW-1:0] rcol_reg;
  logic [1:0]    rbl_reg;
  logic [2:0]    src_bank;
  logic [CW-1:0] src_col;
  logic [1:0]    src_bl;
  logic          src_go;
  logic [DW-1:0] rd0, rd1;

  always_comb begin
    src_bank = rbank_reg;
    src_col  = rcol_reg;
    src_bl   = rbl_reg;
    src_go   = left_reg != 4'h0;
    if (tap_cmd == ldc_pkg::LDC_RD) begin
      src_bank = tap_addr[AW-1:CW];
      src_col  = tap_addr[CW-1:0];
      src_bl   = bl_reg;
      src_go   = 1'b1;
    end else if (tap_cmd == ldc_pkg::LDC_BST) begin
      src_go = 1'b0;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!resetn_i) begin
      left_reg  <= 4'h0;
      rbank_reg <= 3'h0;
      rcol_reg  <= '0;
      rbl_reg   <= `LDC_BL4;
    end else if (ce) begin
      if (!src_go) begin
        left_reg <= 4'h0;
      end else begin
        left_reg  <= (tap_cmd == ldc_pkg::LDC_RD) ? half_m1 : left_reg - 4'h1;
        rbank_reg <= src_bank;
        rbl_reg   <= src_bl;
        rcol_reg  <= {src_col[CW-1:4], ldc_pkg::ldc_col_step(src_col[3:0], src_bl)};
      end
    end
  end

  // ---------------------------------------------------------------
  // Read pins
  // ---------------------------------------------------------------
  logic [DW-1:0] dq_r_reg, dq_f_reg;
  logic          dq_oe_reg, dqs_reg, dqs_oe_reg;

  always_ff @(posedge sys_clk_i) begin
    if (!resetn_i) begin
      dq_r_reg <= '0;
      dq_f_reg <= '0;
    end else if (ce && src_go) begin
      dq_r_reg <= rd0;
      dq_f_reg <= rd1;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!resetn_i) begin
      dq_oe_reg  <= 1'b0;
      dqs_reg    <= 1'b0;
      dqs_oe_reg <= 1'b0;
    end else if (ce) begin
      dq_oe_reg  <= src_go;
      dqs_reg    <= src_go;
      dqs_oe_reg <= src_go || (pre_cmd == ldc_pkg::LDC_RD);
    end
  end

  assign dq_r_o   = dq_r_reg;
  assign dq_f_o   = dq_f_reg;
  assign dq_oe_o  = dq_oe_reg;
  assign dqs_o    = dqs_reg;
  assign dqs_oe_o = dqs_oe_reg;

  // ---------------------------------------------------------------
  // Write burst hand-off to the strobe domain
  // ---------------------------------------------------------------
  logic          wm_tgl_reg, wm_restart_reg;
  logic [2:0]    wm_bank_reg;
  logic [CW-1:0] wm_col_reg;
  logic [1:0]    wm_bl_reg;
  logic [4:0]    wm_len_reg, wm_trunc_reg;
  logic          we;
  logic [AW-1:0] waddr;

  // Fields stay put until the next toggle, far longer than the sync
  always_ff @(posedge sys_clk_i) begin
    if (!resetn_i) begin
      wm_tgl_reg     <= 1'b0;
      wm_restart_reg <= 1'b0;
      wm_bank_reg    <= 3'h0;
      wm_col_reg     <= '0;
      wm_bl_reg      <= `LDC_BL4;
      wm_len_reg     <= 5'h0;
      wm_trunc_reg   <= 5'h0;
    end else if (ce && (is_wr || (is_bst && seen_reg && !last_rd_reg))) begin
      wm_tgl_reg     <= ~wm_tgl_reg;
      wm_restart_reg <= is_wr;
      wm_trunc_reg   <= in_burst ? {gap_reg[3:0], 1'b0} : wm_len_reg;
      if (is_wr) begin
        wm_bank_reg <= act_bank;
        wm_col_reg  <= col_a;
        wm_bl_reg   <= bl_reg;
        wm_len_reg  <= {half, 1'b0};
      end
    end
  end

  ldc_wcap #(
    .CW (CW)
  ) u_wcap (
    .wclk_i    (dqs_clk_i),
    .resetn_i  (resetn_i),
    .msg_tgl_i (wm_tgl_reg),
    .restart_i (wm_restart_reg),
    .bank_i    (wm_bank_reg),
    .col_i     (wm_col_reg),
    .bl_i      (wm_bl_reg),
    .len_i     (wm_len_reg),
    .trunc_i   (wm_trunc_reg),
    .wvalid_i  (dq_wvalid_i),
    .we_o      (we),
    .waddr_o   (waddr)
  );

  ldc_mem #(
    .DW (DW),
    .AW (AW)
  ) u_mem (
    .wclk_i  (dqs_clk_i),
    .we_i    (we),
    .waddr_i (waddr),
    .wd0_i   (dq_wr_r_i),
    .wd1_i   (dq_wr_f_i),
    .raddr_i ({src_bank, src_col}),
    .rd0_o   (rd0),
    .rd1_o   (rd1)
  );

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!resetn_i);

  sequence s_rd3;
    clk_en_i && is_rd && rl_reg == 4'h3;
  endsequence

  sequence s_hold3;
    (clk_en_i && rl_reg == 4'h3)[*3];
  endsequence

  property p_act_open;
    clk_en_i && is_act |=> bank_open_o[$past(act_bank)];
  endproperty
  a_act_open: assert property (p_act_open) else $error("activate left bank closed");

  property p_col_kind;
    clk_en_i && is_col |=> (wm_tgl_reg != $past(wm_tgl_reg)) != $past(is_rd);
  endproperty
  a_col_kind: assert property (p_col_kind) else $error("read or write misdecoded");

  property p_col_addr;
    clk_en_i && is_rd |=> dl_addr[0][CW-1:0] == $past(col_a);
  endproperty
  a_col_addr: assert property (p_col_addr) else $error("start column wrong");

  property p_rl3;
    s_rd3 ##1 s_hold3 |=> dq_oe_o && dqs_o;
  endproperty
  a_rl3: assert property (p_rl3) else $error("read data not at RL");

  property p_pre;
    $rose(dq_oe_o) |-> $past(dqs_oe_o) && !$past(dqs_o);
  endproperty
  a_pre: assert property (p_pre) else $error("read preamble missing");

  property p_rl_cfg;
    clk_en_i && rl_cfg_i >= `LDC_RL_MIN && rl_cfg_i <= 4'(RLMAX) |=> rl_reg == $past(rl_cfg_i);
  endproperty
  a_rl_cfg: assert property (p_rl_cfg) else $error("latency not taken from setting");

  property p_restart;
    clk_en_i && tap_cmd == ldc_pkg::LDC_RD |=> left_reg == $past(half_m1) && dq_oe_o;
  endproperty
  a_restart: assert property (p_restart) else $error("read burst not restarted");

  property p_bst;
    clk_en_i && tap_cmd == ldc_pkg::LDC_BST |=> !dq_oe_o && left_reg == 4'h0;
  endproperty
  a_bst: assert property (p_bst) else $error("terminate did not stop read");

  property p_odd;
    clk_en_i && is_col && in_burst && gap_reg[0] |=> cmd_err_o;
  endproperty
  a_odd: assert property (p_odd) else $error("odd interrupt not flagged");

  property p_mix;
    clk_en_i && is_wr && last_rd_reg && in_burst |=> cmd_err_o;
  endproperty
  a_mix: assert property (p_mix) else $error("write cutting read not flagged");
endmodule

// ---- verification/ldc_host.sv ----
// Purpose: host side model driving the command bus and write strobe
// Assumes: commands launched just after a rising sys clock edge
// Notes:   strobe clock stands still outside write bursts, reset and the edges after reset release
`timescale 1ns/1ns
module ldc_host (
  input  wire logic   clk_i,
  output logic        cs_n_o,
  output logic [9:0]  ca_r_o,
  output logic [9:0]  ca_f_o,
  output logic        dqs_clk_o,
  output logic        dq_wvalid_o,
  output logic [15:0] dq_wr_r_o,
  output logic [15:0] dq_wr_f_o
);
  initial begin
    cs_n_o = 1'b1;
    ca_r_o = 10'h000;
    ca_f_o = 10'h000;
    dqs_clk_o = 1'b0;
    dq_wvalid_o = 1'b0;
    dq_wr_r_o = 16'h0000;
    dq_wr_f_o = 16'h0000;
  end

  // One command, held a full cycle; bank opened first by caller, except the closed-bank read of t_err
  // Idle cycle between commands and few activates keep row spacing and window
  task automatic cmd(input logic [9:0] r, input logic [9:0] f);
    @(posedge clk_i);
    cs_n_o <= 1'b0;
    ca_r_o <= r;
    ca_f_o <= f;
    @(posedge clk_i);
    cs_n_o <= 1'b1;
    ca_r_o <= ~r;
    ca_f_o <= ~f;
  endtask

  task automatic lclk(input int n);
    repeat (n) begin
      #3 dqs_clk_o = 1'b1;
      #3 dqs_clk_o = 1'b0;
    end
  endtask

  // Three strobe clocks as preamble, then one pair per edge
  task automatic wburst(input int pairs, input logic [15:0] base);
    lclk(3);
    for (int k = 0; k < pairs; k++) begin
      dq_wvalid_o = 1'b1;
      dq_wr_r_o = base + 16'(2 * k);
      dq_wr_f_o = base + 16'(2 * k + 1);
      lclk(1);
    end
    dq_wvalid_o = 1'b0;
    dq_wr_r_o = ~dq_wr_r_o;
    dq_wr_f_o = ~dq_wr_f_o;
    lclk(2);
  endtask
endmodule

// ---- verification/tb_top.sv ----
// Purpose: self-checking bench for command decode and burst datapath
// Assumes: RL 3 unless set, bursts on banks 3 and 5
// Notes:   expectations come from command encodings only
`timescale 1ns/1ns
`include "ldc_cfg.svh"
`define CHK(nm, exp, got) begin check_count++; if ((got) !== (exp)) begin $display("MISMATCH %s exp %0h got %0h", nm, exp, got); err_total++; end end
module tb_top;
  logic        sys_clk_i;
  logic        resetn_i;
  logic        clk_en_i = 1'b1;  // Never toggled, so every level outlasts its minimum
  logic [3:0]  rl_cfg_i;
  logic [1:0]  bl_cfg_i;
  logic        cs_n_i, dqs_clk_i, dq_wvalid_i;
  logic [9:0]  ca_r_i, ca_f_i;
  logic [15:0] dq_wr_r_i, dq_wr_f_i, dq_r_o, dq_f_o;
  logic        dq_oe_o, dqs_o, dqs_oe_o, cmd_err_o;
  logic [7:0]  bank_open_o;
  int          err_total = 0;
  int          check_count = 0;
  int          cyc = 0;

  ldc_host host (.clk_i(sys_clk_i), .cs_n_o(cs_n_i), .ca_r_o(ca_r_i), .ca_f_o(ca_f_i), .dqs_clk_o(dqs_clk_i),
    .dq_wvalid_o(dq_wvalid_i), .dq_wr_r_o(dq_wr_r_i), .dq_wr_f_o(dq_wr_f_i));
  ldc_top #(.DW(16), .CW(6), .RLMAX(8)) uut (.sys_clk_i(sys_clk_i), .resetn_i(resetn_i), .clk_en_i(clk_en_i),
    .cs_n_i(cs_n_i), .ca_r_i(ca_r_i), .ca_f_i(ca_f_i), .rl_cfg_i(rl_cfg_i), .bl_cfg_i(bl_cfg_i),
    .dqs_clk_i(dqs_clk_i), .dq_wvalid_i(dq_wvalid_i), .dq_wr_r_i(dq_wr_r_i), .dq_wr_f_i(dq_wr_f_i),
    .dq_r_o(dq_r_o), .dq_f_o(dq_f_o), .dq_oe_o(dq_oe_o), .dqs_o(dqs_o), .dqs_oe_o(dqs_oe_o),
    .bank_open_o(bank_open_o), .cmd_err_o(cmd_err_o));

  initial begin
    sys_clk_i = 1'b0;
    forever #10 sys_clk_i = ~sys_clk_i;
  end

  task automatic print_verdict;
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  task automatic t_act;
    `CHK("open_rst", 8'h00, bank_open_o)
    host.cmd({3'h3, 7'h02}, 10'h000);
    #1 `CHK("open", 8'h08, bank_open_o)
    host.cmd({3'h5, 7'h02}, 10'h000);
    #1 `CHK("open", 8'h28, bank_open_o)
    $display("test act done");
  endtask

  // Write from column 22, read from 20: wrap and both address halves
  task automatic t_wr_rd;
    logic [15:0] b;
    for (int rl = 3; rl <= 5; rl += 2) begin
      b = 16'h1100 * 16'(rl);
      rl_cfg_i <= 4'(rl);
      host.cmd({3'h3, 2'h2, 5'h01}, 10'h00a);
      host.wburst(2, b);
      // Plain read without auto-precharge; next write comes many clocks later
      host.cmd({3'h3, 2'h0, 5'h05}, 10'h00a);
      repeat (rl - 1) @(posedge sys_clk_i);
      #1 `CHK("dqs_oe", 1'b1, dqs_oe_o)
      `CHK("dqs_pre", 1'b0, dqs_o)
      for (int k = 0; k < 2; k++) begin
        @(posedge sys_clk_i);
        #1 `CHK("dq_oe", 1'b1, dq_oe_o)
        `CHK("dq_r", b + 16'(2 - 2 * k), dq_r_o)
        `CHK("dq_f", b + 16'(3 - 2 * k), dq_f_o)
      end
      @(posedge sys_clk_i);
      #1 `CHK("dq_end", 1'b0, dq_oe_o)
    end
    $display("test write read done");
  endtask

  task automatic t_err;
    host.cmd({3'h0, 7'h05}, 10'h000);
    #1 `CHK("err", 1'b1, cmd_err_o)
    @(posedge sys_clk_i);
    #1 `CHK("err_end", 1'b0, cmd_err_o)
    repeat (8) @(posedge sys_clk_i);
    $display("test closed bank done");
  endtask

  // Seamless BL4, BL8 cut by read, BL8 cut by terminate
  task automatic t_cut;
    int c;
    rl_cfg_i <= 4'h3;
    for (int i = 0; i < 3; i++) begin
      c = 0;
      bl_cfg_i <= (i == 0) ? `LDC_BL4 : `LDC_BL8;
      host.cmd({3'h3, 7'h05}, 10'h000);
      host.cmd((i == 2) ? 10'h003 : {3'h5, 7'h05}, 10'h000);
      repeat (12) begin
        @(posedge sys_clk_i);
        #1 if (dq_oe_o === 1'b1) c++;
      end
      `CHK("data_clks", (i == 0) ? 4 : (i == 1) ? 6 : 2, c)
    end
    host.cmd({3'h3, 7'h0b}, 10'h000);
    #1 `CHK("pre", 8'h20, bank_open_o)
    host.cmd(10'h01b, 10'h000);
    #1 `CHK("pre_all", 8'h00, bank_open_o)
    $display("test burst cut done");
  endtask

  always @(posedge sys_clk_i) begin
    cyc++;
    if (cyc == 3000) begin
      err_total++;
      print_verdict();
    end
  end

  initial begin
    resetn_i = 1'b0;
    rl_cfg_i = 4'h3;
    bl_cfg_i = `LDC_BL4;
    host.lclk(4);
    repeat (8) @(posedge sys_clk_i);
    resetn_i <= 1'b1;
    // Link-side reset synchroniser needs strobe edges after release
    host.lclk(3);
    t_act();
    t_wr_rd();
    t_err();
    t_cut();
    print_verdict();
  end
endmodule
